// File: dtc_host.sv
// Purpose: Host model driving the command port of the tone generator
// Assumes: Tasks are called from the bench, drives land 2 ns after a clock edge
// Notes: Shift clock idles high and stands still between words
`timescale 1ns/10ps
module dtc_host
   import dtc_pkg::*;
(
   input wire logic clock_in,
   output logic chip_en_n_out,
   output logic parallel_sel_out,
   output logic shift_clk_out,
   output logic shift_data_out,
   output logic [PAR_W-1:0] parallel_code_out
);
   // 100 kHz shift clock at 40 MHz
   localparam int SCK_HALF = 200;

   initial begin
      chip_en_n_out = 1'h1;
      parallel_sel_out = 1'h0;
      shift_clk_out = 1'h1;
      shift_data_out = 1'h1;
      parallel_code_out = 4'h0;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clock_in);
      #2;
   endtask : step

   task automatic set_ce(input logic v);
      step(1);
      chip_en_n_out = v;
   endtask : set_ce

   // Mode and code settle before any chip enable change
   task automatic setup(input logic par, input logic [PAR_W-1:0] code);
      step(1);
      parallel_sel_out = par;
      parallel_code_out = code;
   endtask : setup

   // Bits go out least significant first, held across the falling edge
   task automatic send(input logic [CODE_W-1:0] word, input int n);
      for (int i = 0; i < n; i++) begin
         step(1);
         shift_data_out = word[i];
         step(SCK_HALF);
         shift_clk_out = 1'h0;
         step(SCK_HALF);
         shift_clk_out = 1'h1;
      end
      step(1);
      // Released data line shows no stale value
      shift_data_out = ~shift_data_out;
   endtask : send
endmodule : dtc_host

// File: dtc_osc_tick.sv
// Purpose: System oscillator enable pulse, ticking from run_in high with no start-up delay
// Assumes: Single 40 MHz clock
// Notes: Pulses only while run_in is high
`timescale 1ns/10ps
module dtc_osc_tick
   import dtc_pkg::*;
(
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic run_in,
   output logic tick_out
);
   logic [15:0] acc_r;
   logic [15:0] acc_nxt;
   logic tick_r;
   logic tick_nxt;
   logic [16:0] acc_sum;

   // One spare bit so the sum cannot wrap before it is compared
   assign acc_sum = {1'b0, acc_r} + {1'b0, OSC_ACC_STEP};

   always_comb begin
      acc_nxt = acc_r;
      tick_nxt = 1'b0;
      if (!run_in) begin
         acc_nxt = '0;
      end else if (acc_sum >= {1'b0, OSC_ACC_MOD}) begin
         acc_nxt = 16'(acc_sum - {1'b0, OSC_ACC_MOD});
         tick_nxt = 1'b1;
      end else begin
         acc_nxt = acc_sum[15:0];
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         acc_r <= '0;
         tick_r <= 1'b0;
      end else begin
         acc_r <= acc_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick_out = tick_r;
endmodule : dtc_osc_tick

// File: dtc_pkg.sv
// Purpose: Shared constants and types for the dual tone command port
// Assumes: 40 MHz system clock
// Notes: Tone dividers give a square wave per tone group
package dtc_pkg;
   localparam int CLK_HZ = 40000000;
   localparam int SYS_OSC_HZ = 3579500;
   localparam int CODE_W = 5;
   localparam int PAR_W = 4;
   localparam int DIV_W = 12;
   localparam logic [4:0] CODE_OFF = 5'h1F;
   localparam logic [4:0] CODE_SINGLE_MAX = 5'h17;
   localparam int OSC_STARTUP_MS = 10;
   localparam int TONE_START_DELAY_MS = 6;
   localparam int OSC_STARTUP_CYC = (CLK_HZ / 1000) * OSC_STARTUP_MS;
   localparam int TONE_START_CYC = (CLK_HZ / 1000) * TONE_START_DELAY_MS;
   // System oscillator enable: one pulse per 3.5795 MHz tick, fractional accumulator
   localparam logic [15:0] OSC_ACC_STEP = 16'h165F;
   localparam logic [15:0] OSC_ACC_MOD = 16'hFA00;
   // Half-period counts in system oscillator ticks, rows then columns
   localparam logic [11:0] HALF_697 = 12'hA08;
   localparam logic [11:0] HALF_770 = 12'h914;
   localparam logic [11:0] HALF_852 = 12'h835;
   localparam logic [11:0] HALF_941 = 12'h76E;
   localparam logic [11:0] HALF_1209 = 12'h5C8;
   localparam logic [11:0] HALF_1336 = 12'h53C;
   localparam logic [11:0] HALF_1477 = 12'h4BC;
   localparam logic [11:0] HALF_1633 = 12'h448;
   typedef enum logic [1:0] {DTC_IDLE, DTC_WAIT, DTC_RUN} dtc_state_t;
endpackage : dtc_pkg

// File: dtc_port.sv
// Purpose: Command port and tone selection of a dual tone generator
// Assumes: All inputs synchronous to clock_in
// Notes: Tone outputs are square waves, one per group, plus an active flag
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Serial word is five bits, least significant first, top bit last.
// - Serial data sampled on each falling edge of the shift clock.
// - Mode input low selects serial, high parallel; serial ignores parallel code.
// - Serial top bit clear gives the sixteen dual tones, 0 meaning D.
// - Serial codes 16 to 23 give one single tone in ascending order.
// - Serial all-ones code silences output; codes 24 to 30 unused.
// - Parallel code is four bits with the same dual tone mapping.
// - Parallel tone starts after chip enable goes low.
// - Parallel tone appears about 6 ms after the oscillator start-up.
// - Oscillator reaches normal operation within 10 ms of chip enable falling.
// - Tones come from dividing the 3.5795 MHz system clock.
module dtc_port
   import dtc_pkg::*;
#(
   parameter int OSC_CYC = OSC_STARTUP_CYC,
   parameter int START_CYC = TONE_START_CYC
) (
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic chip_en_n_in,
   input wire logic parallel_sel_in,
   input wire logic shift_clk_in,
   input wire logic shift_data_in,
   input wire logic [PAR_W-1:0] parallel_code_in,
   output logic row_tone_out,
   output logic col_tone_out,
   output logic tone_active_out,
   output logic osc_ready_out
);
   ////////////////////////////////////////////////////////////////////////////
   // Command capture
   dtc_state_t state_r;
   dtc_state_t state_nxt;
   logic [22:0] dly_r;
   logic [22:0] dly_nxt;
   logic shift_clk_d_r;
   logic [CODE_W-1:0] sh_r;
   logic [CODE_W-1:0] sh_nxt;
   logic [2:0] bits_r;
   logic [2:0] bits_nxt;
   logic [CODE_W-1:0] code_r;
   logic [CODE_W-1:0] code_nxt;
   logic osc_ready_r;
   logic osc_ready_nxt;
   logic tone_on_r;
   logic tone_on_nxt;
   logic [CODE_W-1:0] shifted;
   logic fall;

   assign fall = shift_clk_d_r & ~shift_clk_in;
   assign shifted = {shift_data_in, sh_r[CODE_W-1:1]};

   always_comb begin
      state_nxt = state_r;
      dly_nxt = dly_r;
      sh_nxt = sh_r;
      bits_nxt = bits_r;
      code_nxt = code_r;
      osc_ready_nxt = osc_ready_r;
      tone_on_nxt = tone_on_r;
      if (chip_en_n_in) begin
         state_nxt = DTC_IDLE;
         dly_nxt = '0;
         bits_nxt = '0;
         osc_ready_nxt = 1'b0;
         tone_on_nxt = 1'b0;
         code_nxt = CODE_OFF;
      end else begin
         unique case (state_r)
            DTC_IDLE: begin
               state_nxt = DTC_WAIT;
               dly_nxt = '0;
               bits_nxt = '0;
               if (parallel_sel_in) begin
                  code_nxt = {1'b0, parallel_code_in};
               end else begin
                  code_nxt = CODE_OFF;
               end
            end
            DTC_WAIT: begin
               dly_nxt = dly_r + 1'b1;
               if (dly_r == 23'(OSC_CYC - 1)) begin
                  osc_ready_nxt = 1'b1;
               end
               if (dly_r == 23'(OSC_CYC + START_CYC - 1)) begin
                  state_nxt = DTC_RUN;
                  tone_on_nxt = 1'b1;
               end
            end
            DTC_RUN: begin
            end
         endcase
         if (!parallel_sel_in && fall) begin
            if (bits_r == 3'(CODE_W - 1)) begin
               bits_nxt = '0;
               code_nxt = shifted;
            end else begin
               bits_nxt = bits_r + 1'b1;
               sh_nxt = shifted;
            end
         end
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_r <= DTC_IDLE;
         dly_r <= '0;
         shift_clk_d_r <= 1'b1;
         sh_r <= '0;
         bits_r <= '0;
         code_r <= CODE_OFF;
         osc_ready_r <= 1'b0;
         tone_on_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         dly_r <= dly_nxt;
         shift_clk_d_r <= shift_clk_in;
         sh_r <= sh_nxt;
         bits_r <= bits_nxt;
         code_r <= code_nxt;
         osc_ready_r <= osc_ready_nxt;
         tone_on_r <= tone_on_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Code decode to half-period counts
   logic [DIV_W-1:0] row_half;
   logic [DIV_W-1:0] col_half;
   logic tone_active_nxt;

   always_comb begin
      row_half = '0;
      col_half = '0;
      if (!code_r[4]) begin
         unique case (code_r[3:0])
            4'h1: begin row_half = HALF_697; col_half = HALF_1209; end
            4'h2: begin row_half = HALF_697; col_half = HALF_1336; end
            4'h3: begin row_half = HALF_697; col_half = HALF_1477; end
            4'h4: begin row_half = HALF_770; col_half = HALF_1209; end
            4'h5: begin row_half = HALF_770; col_half = HALF_1336; end
            4'h6: begin row_half = HALF_770; col_half = HALF_1477; end
            4'h7: begin row_half = HALF_852; col_half = HALF_1209; end
            4'h8: begin row_half = HALF_852; col_half = HALF_1336; end
            4'h9: begin row_half = HALF_852; col_half = HALF_1477; end
            4'hA: begin row_half = HALF_941; col_half = HALF_1336; end
            4'hB: begin row_half = HALF_941; col_half = HALF_1209; end
            4'hC: begin row_half = HALF_941; col_half = HALF_1477; end
            4'hD: begin row_half = HALF_697; col_half = HALF_1633; end
            4'hE: begin row_half = HALF_770; col_half = HALF_1633; end
            4'hF: begin row_half = HALF_852; col_half = HALF_1633; end
            4'h0: begin row_half = HALF_941; col_half = HALF_1633; end
         endcase
      end else if (code_r <= CODE_SINGLE_MAX) begin
         unique case (code_r[2:0])
            3'h0: row_half = HALF_697;
            3'h1: row_half = HALF_770;
            3'h2: row_half = HALF_852;
            3'h3: row_half = HALF_941;
            3'h4: col_half = HALF_1209;
            3'h5: col_half = HALF_1336;
            3'h6: col_half = HALF_1477;
            3'h7: col_half = HALF_1633;
         endcase
      end
      // Codes 24 to 31 leave both halves zero: silence
      if (!tone_on_r) begin
         row_half = '0;
         col_half = '0;
      end
      // Standby clears the flag one edge before the tone waves go low
      tone_active_nxt = !chip_en_n_in && ((row_half != '0) || (col_half != '0));
   end

   ////////////////////////////////////////////////////////////////////////////
   // Tone generation
   logic osc_tick;
   logic row_wave;
   logic col_wave;
   logic tone_active_r;

   dtc_osc_tick u_osc (
      .clock_in(clock_in),
      .resetn_in(resetn_in),
      .run_in(!chip_en_n_in),
      .tick_out(osc_tick)
   );

   dtc_tone_div #(.W(DIV_W)) u_row (
      .clock_in(clock_in),
      .resetn_in(resetn_in),
      .osc_tick_in(osc_tick),
      .half_in(row_half),
      .wave_out(row_wave)
   );

   dtc_tone_div #(.W(DIV_W)) u_col (
      .clock_in(clock_in),
      .resetn_in(resetn_in),
      .osc_tick_in(osc_tick),
      .half_in(col_half),
      .wave_out(col_wave)
   );

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tone_active_r <= 1'b0;
      end else begin
         tone_active_r <= tone_active_nxt;
      end
   end

   assign row_tone_out = row_wave;
   assign col_tone_out = col_wave;
   assign tone_active_out = tone_active_r;
   assign osc_ready_out = osc_ready_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   AST_STANDBY_SILENT: assert property (@(posedge clock_in)
      disable iff (!resetn_in) chip_en_n_in |=> !tone_active_out && !osc_ready_out)
      else $error("tone active in standby");
   AST_OFF_SILENT: assert property (@(posedge clock_in)
      disable iff (!resetn_in) (code_r == CODE_OFF) |=> !tone_active_out)
      else $error("off code not silent");
   AST_SERIAL_LOAD: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (!chip_en_n_in && !parallel_sel_in && fall && bits_r == 3'h4)
      |=> code_r == $past(shifted))
      else $error("serial word not applied");
   AST_NO_PARALLEL_IN_SERIAL: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (!chip_en_n_in && !parallel_sel_in && !fall && state_r != DTC_IDLE)
      |=> $stable(code_r))
      else $error("code changed without serial edge");
   AST_PAR_CODE: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (!chip_en_n_in && parallel_sel_in && state_r == DTC_IDLE)
      |=> code_r == {1'b0, $past(parallel_code_in)})
      else $error("parallel code not captured");
   AST_OSC_READY: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (state_r == DTC_WAIT && dly_r == 23'(OSC_CYC - 1) && !chip_en_n_in)
      |=> osc_ready_out)
      else $error("oscillator not ready in time");
   AST_TONE_DELAY: assert property (@(posedge clock_in)
      disable iff (!resetn_in) (state_r == DTC_WAIT) |-> !tone_on_r)
      else $error("tone before start delay");
   AST_DUAL: assert property (@(posedge clock_in)
      disable iff (!resetn_in) (tone_on_r && !code_r[4] && !chip_en_n_in) |=> tone_active_out)
      else $error("dual tone missing");
   AST_SINGLE: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (tone_on_r && code_r[4:3] == 2'b10) |-> ((row_half == '0) != (col_half == '0)))
      else $error("single tone not single");
   AST_STANDBY_WAVES: assert property (@(posedge clock_in)
      disable iff (!resetn_in) chip_en_n_in |=> ##1 (!row_tone_out && !col_tone_out))
      else $error("tone wave in standby");
   AST_OSC_STOPPED: assert property (@(posedge clock_in)
      disable iff (!resetn_in) chip_en_n_in |=> !osc_tick)
      else $error("oscillator ticking in standby");
   AST_PARTIAL_DROP: assert property (@(posedge clock_in)
      disable iff (!resetn_in) chip_en_n_in |=> bits_r == 3'h0)
      else $error("partial word kept in standby");
   AST_BIT_COUNT: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (!chip_en_n_in && !parallel_sel_in && fall && bits_r != 3'h4)
      |=> bits_r == $past(bits_r) + 3'h1)
      else $error("serial bit not counted");
   AST_PAR_HOLD: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (!chip_en_n_in && parallel_sel_in && state_r != DTC_IDLE) |=> $stable(code_r))
      else $error("code changed in parallel run");
   AST_OSC_NOT_EARLY: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (state_r == DTC_WAIT && dly_r < 23'(OSC_CYC - 1)) |=> !osc_ready_out)
      else $error("oscillator ready too early");
   AST_TONE_ON_TIME: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (state_r == DTC_WAIT && dly_r == 23'(OSC_CYC + START_CYC - 1) && !chip_en_n_in)
      |=> tone_on_r)
      else $error("tone not started after delay");
   AST_OFF_WAVES: assert property (@(posedge clock_in)
      disable iff (!resetn_in) (code_r == CODE_OFF) |=> !row_tone_out && !col_tone_out)
      else $error("off code leaves a wave");

   // Main scenarios
   COV_SERIAL: cover property (@(posedge clock_in) fall && bits_r == 3'h4 && !parallel_sel_in);
   COV_PAR_RUN: cover property (@(posedge clock_in) parallel_sel_in && tone_on_r);
   COV_STANDBY: cover property (@(posedge clock_in) tone_on_r ##1 chip_en_n_in);
   COV_SINGLE: cover property (@(posedge clock_in) tone_on_r && code_r[4:3] == 2'b10);
   COV_OFF: cover property (@(posedge clock_in) tone_on_r && code_r == CODE_OFF);
endmodule : dtc_port

// File: dtc_port_bench.sv
// Purpose: Self-checking bench for the dual tone command port
// Assumes: Shortened start-up counts, host model drives all port inputs except clock and reset
// Notes: Tone pitch judged by the half period of the group square waves
`timescale 1ns/10ps
module dtc_port_bench
   import dtc_pkg::*;
;
   localparam int OSC = 20;
   localparam int START = 12;
   logic clock_in = 1'h0;
   logic resetn_in = 1'h0;
   logic chip_en_n, parallel_sel, shift_clk, shift_data;
   logic [PAR_W-1:0] parallel_code;
   logic row_tone, col_tone, tone_active, osc_ready;
   int error_cnt = 0;
   int tests_run = 0;

   always #12.5 clock_in = ~clock_in;

   dtc_host host (
      .clock_in(clock_in),
      .chip_en_n_out(chip_en_n),
      .parallel_sel_out(parallel_sel),
      .shift_clk_out(shift_clk),
      .shift_data_out(shift_data),
      .parallel_code_out(parallel_code)
   );

   dtc_port #(.OSC_CYC(OSC), .START_CYC(START)) dut (
      .clock_in(clock_in),
      .resetn_in(resetn_in),
      .chip_en_n_in(chip_en_n),
      .parallel_sel_in(parallel_sel),
      .shift_clk_in(shift_clk),
      .shift_data_in(shift_data),
      .parallel_code_in(parallel_code),
      .row_tone_out(row_tone),
      .col_tone_out(col_tone),
      .tone_active_out(tone_active),
      .osc_ready_out(osc_ready)
   );

////////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude

   task automatic check_bit(input string what, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask : check_bit

   task automatic check_range(input string what, input int lo, input int hi, input int got);
      tests_run++;
      if (got < lo || got > hi) begin
         error_cnt++;
         $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
      end
   endtask : check_range

   task automatic tick(input int n);
      n--;
      if (n > 30000) begin
         error_cnt++;
         conclude();
      end
   endtask : tick

   // Edges from chip enable low until the chosen flag rises
   task automatic count_rise(input bit tone, output int n);
      n = 0;
      do begin
         @(posedge clock_in);
         #1;
         n++;
         if (n > 1000) tick(40000);
      end while ((tone ? tone_active : osc_ready) !== 1'h1);
   endtask : count_rise

   // Half period in clocks, allowing 1 percent around the nominal
   task automatic check_tone(input string what, input bit col, input int hz);
      logic last;
      int n;
      int exp;
      exp = CLK_HZ / (2 * hz);
      for (int k = 0; k < 2; k++) begin
         n = 0;
         last = col ? col_tone : row_tone;
         while ((col ? col_tone : row_tone) === last) begin
            @(posedge clock_in);
            #1;
            n++;
            tick(n);
         end
      end
      check_range(what, exp - exp / 100, exp + exp / 100, n);
   endtask : check_tone

////////////////////////////////////////////////////////////////////////////////
   task automatic sc_reset();
      check_bit("tone active at reset", 1'h0, tone_active);
      check_bit("osc ready at reset", 1'h0, osc_ready);
   endtask : sc_reset

   task automatic sc_standby();
      host.setup(1'h0, 4'hC);
      host.send(5'h0D, 5);
      check_bit("standby tone", 1'h0, tone_active);
      check_bit("standby osc", 1'h0, osc_ready);
      check_bit("standby row", 1'h0, row_tone);
      check_bit("standby column", 1'h0, col_tone);
   endtask : sc_standby

   task automatic sc_serial();
      int n;
      host.set_ce(1'h0);
      count_rise(1'h0, n);
      check_range("osc start-up", OSC, OSC + 3, n);
      host.step(START + 4);
      check_bit("tone before word", 1'h0, tone_active);
      host.send(5'h0D, 5);
      check_bit("tone after word", 1'h1, tone_active);
      check_tone("serial column", 1'h1, 1633);
      host.send(5'h1F, 4);
      check_bit("tone on partial word", 1'h1, tone_active);
      host.send(5'h01, 1);
      check_bit("tone after off code", 1'h0, tone_active);
      host.send(5'h17, 5);
      check_bit("single tone", 1'h1, tone_active);
      check_bit("single tone row", 1'h0, row_tone);
      host.send(5'h1F, 5);
      check_bit("off code word", 1'h0, tone_active);
      host.set_ce(1'h1);
      host.step(3);
      check_bit("osc after disable", 1'h0, osc_ready);
   endtask : sc_serial

   task automatic sc_parallel();
      int n;
      host.setup(1'h1, 4'hC);
      host.set_ce(1'h0);
      count_rise(1'h1, n);
      check_range("parallel tone delay", OSC + START, OSC + START + 4, n);
      check_bit("osc ready in parallel", 1'h1, osc_ready);
      check_tone("parallel column", 1'h1, 1477);
      host.send(5'h1F, 5);
      check_bit("serial ignored", 1'h1, tone_active);
      host.set_ce(1'h1);
      host.step(3);
      check_bit("tone after disable", 1'h0, tone_active);
   endtask : sc_parallel

   // Reset in the middle of a start-up, chip enable held low throughout
   task automatic sc_midreset();
      int n;
      host.setup(1'h1, 4'h0);
      host.set_ce(1'h0);
      host.step(OSC + 2);
      check_bit("osc ready before reset", 1'h1, osc_ready);
      resetn_in = 1'h0;
      host.step(2);
      check_bit("osc ready in reset", 1'h0, osc_ready);
      check_bit("tone in reset", 1'h0, tone_active);
      resetn_in = 1'h1;
      count_rise(1'h1, n);
      check_range("tone delay after reset", OSC + START, OSC + START + 4, n);
      check_bit("osc ready after reset", 1'h1, osc_ready);
      host.set_ce(1'h1);
      host.step(3);
      check_bit("tone after last disable", 1'h0, tone_active);
   endtask : sc_midreset

////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clock_in);
      #2;
      resetn_in = 1'h1;
      sc_reset();
      sc_standby();
      sc_serial();
      sc_parallel();
      sc_midreset();
      conclude();
   end
endmodule : dtc_port_bench

// File: dtc_tone_div.sv
// Purpose: Square wave generator for one tone group
// Assumes: osc_tick_in is a one-cycle enable at the system oscillator rate
// Notes: Half period zero silences the output
`timescale 1ns/10ps
module dtc_tone_div
   import dtc_pkg::*;
#(
   parameter int W = DIV_W
) (
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic osc_tick_in,
   input wire logic [W-1:0] half_in,
   output logic wave_out
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic wave_r;
   logic wave_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      wave_nxt = wave_r;
      if (half_in == '0) begin
         cnt_nxt = '0;
         wave_nxt = 1'b0;
      end else if (osc_tick_in) begin
         if (cnt_r >= half_in - 1'b1) begin
            cnt_nxt = '0;
            wave_nxt = ~wave_r;
         end else begin
            cnt_nxt = cnt_r + 1'b1;
         end
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cnt_r <= '0;
         wave_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         wave_r <= wave_nxt;
      end
   end

   assign wave_out = wave_r;
endmodule : dtc_tone_div
